// [pkg/fcv_regs.vh]
`ifndef FCV_REGS_VH
`define FCV_REGS_VH
// ****************************************
// register indices (byte address = 4 x)
// ****************************************
`define FCV_IDX_SMOOTH 8'h10
`define FCV_IDX_THYS 8'h11
`define FCV_IDX_CORE 8'h21
`define FCV_IDX_MAIN 8'h22
`define FCV_IDX_CFG1 8'h40
`define FCV_IDX_ISTAT 8'h41
`define FCV_IDX_IMASK 8'h42
`define FCV_IDX_EXT1 8'h76
`define FCV_IDX_EXT2 8'h77
// ****************************************
// field positions and masks
// ****************************************
`define FCV_SLOW_R1 0
`define FCV_SLOW_LOC 1
`define FCV_SLOW_R2 2
`define FCV_THM_MAN 3
`define FCV_CORE_GUARD 6
`define FCV_FURTHER 7
`define FCV_HYS_OFF 0
`define FCV_LOCK 1
`define FCV_IS_CORE 1
`define FCV_IS_THERMAL_LIMIT_SIGNAL 0
`define FCV_SMOOTH_WMASK 8'hCF
`define FCV_THYS_WMASK 8'h01
`define FCV_IRQ_WMASK 8'h03
// ****************************************
// reset values and smoothing scales
// ****************************************
`define FCV_RST8 8'h00
`define FCV_RST10 10'h000
`define FCV_RD_ZERO 32'h0000_0000
`define FCV_SCALE_BASE 13'h03E8
`define FCV_SCALE_X4 13'h0FA0
`define FCV_SCALE_EXTRA 13'h0188
`define FCV_PER_MILLE 13'h03E8
`endif

// [verilog/fcv_top.v]
// The APB register port was decided locally.
`timescale 1ns/10ps
`include "fcv_regs.vh"
// Overview of operation
// - bit 0 set: fan 1 smoothing for remote 1 channel times four
// - bit 1 set: fan 2 smoothing for local channel times four
// - bit 2 set: fan 3 smoothing for remote 2 channel times four
// - bit 3 set: thermal limit signal stays active in manual fan mode
// - guard on and core supply under limit: flag, alert, stop hot monitoring
// - core supply back above limit: resume hot monitoring, spin up fans
// - bit 7 set: every fan smoothing time grows by 39.2 percent
// - thermal limit event overrides any fan setting, even fans disabled
// - once locked, both configuration registers ignore all writes
// - hysteresis-off bit set: thermal limit compare has no hysteresis
// - core and main supply top eight bits read-only at 0x21, 0x22
// - extended read freezes extended and top bytes until those are read
// - both configuration and both voltage registers reset to zero
// - lock bit set only once; freezes lockable registers until reset
module fcv_top
(
  // clock and reset
  input wire clk,
  input wire rstn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // converter results
  input wire sample_valid,
  input wire [9:0] core_supply_input,
  input wire [9:0] main_supply_input,
  input wire [7:0] core_low_limit,
  // thermal compare and fan mode
  input wire temp_over_limit,
  input wire temp_above_hys_band,
  input wire manual_mode,
  input wire fans_disabled,
  // fan and monitor control
  output reg thermal_limit_signal,
  output reg fan_full_on,
  output reg processor_hot_mon_en,
  output reg fan_spinup,
  output reg [12:0] fan1_smooth_scale,
  output reg [12:0] fan2_smooth_scale,
  output reg [12:0] fan3_smooth_scale,
  // interrupt
  output wire irq
);

  // ****************************************
  // smoothing scale in per mille of base
  // ****************************************
  function [12:0] scale;
    input slow;
    input further;
    reg [25:0] prod;
    begin
      scale = slow ? `FCV_SCALE_X4 : `FCV_SCALE_BASE;
      prod = scale * `FCV_SCALE_EXTRA;
      if (further)
      begin
        scale = scale + pm(prod);
      end
    end
  endfunction

  // prod / 1000, cut to 13 bits
  function [12:0] pm;
    input [25:0] p;
    reg [25:0] q;
    begin
      q = p / {13'h0000, `FCV_PER_MILLE};
      pm = q[12:0];
    end
  endfunction

  // ****************************************
  // registers
  // ****************************************
  reg [7:0] smooth_ff;
  reg [7:0] thys_ff;
  reg lock_ff;
  reg [7:0] core_rd_ff;
  reg [7:0] main_rd_ff;
  reg [1:0] core_ext_ff;
  reg [1:0] main_ext_ff;
  reg freeze_ff;
  reg core_seen_ff;
  reg main_seen_ff;
  reg [1:0] istat_ff;
  reg [1:0] imask_ff;
  reg core_low_ff;
  reg thermal_limit_signal_ff;

  // ****************************************
  // bus decode
  // ****************************************
  wire [7:0] idx;
  wire aligned;
  wire acc;
  wire wr;
  wire rd;
  wire setup;
  reg mapped;

  assign idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign acc = psel & penable;
  assign setup = psel & ~penable;
  assign wr = acc & pwrite & mapped;
  assign rd = acc & ~pwrite & mapped;
  // zero wait states: every access ends in one cycle
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  always @*
  begin
    case (idx)
      `FCV_IDX_SMOOTH,
      `FCV_IDX_THYS,
      `FCV_IDX_CORE,
      `FCV_IDX_MAIN,
      `FCV_IDX_CFG1,
      `FCV_IDX_ISTAT,
      `FCV_IDX_IMASK,
      `FCV_IDX_EXT1,
      `FCV_IDX_EXT2:
        mapped = aligned;
      default:
        mapped = 1'b0;
    endcase
  end

  wire wr_smooth;
  wire wr_thys;
  wire wr_cfg1;
  wire wr_imask;
  wire rd_core;
  wire rd_main;
  wire rd_ext;
  wire ext_hit;
  wire rd_istat;

  assign wr_smooth = wr & (idx == `FCV_IDX_SMOOTH);
  assign wr_thys = wr & (idx == `FCV_IDX_THYS);
  assign wr_cfg1 = wr & (idx == `FCV_IDX_CFG1);
  assign wr_imask = wr & (idx == `FCV_IDX_IMASK);
  assign rd_core = rd & (idx == `FCV_IDX_CORE);
  assign rd_main = rd & (idx == `FCV_IDX_MAIN);
  assign ext_hit = (idx == `FCV_IDX_EXT1) | (idx == `FCV_IDX_EXT2);
  assign rd_ext = rd & ext_hit;
  assign rd_istat = rd & (idx == `FCV_IDX_ISTAT);

  // ****************************************
  // configuration registers
  // ****************************************
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      smooth_ff <= `FCV_RST8;
      thys_ff <= `FCV_RST8;
      lock_ff <= 1'b0;
      imask_ff <= 2'b00;
    end
    else
    begin
      if (wr_smooth & ~lock_ff)
        smooth_ff <= pwdata[7:0] & `FCV_SMOOTH_WMASK;
      if (wr_thys & ~lock_ff)
        thys_ff <= pwdata[7:0] & `FCV_THYS_WMASK;
      // lock sets once, only reset clears it
      if (wr_cfg1 & pwdata[`FCV_LOCK])
        lock_ff <= 1'b1;
      if (wr_imask)
        imask_ff <= pwdata[1:0];
    end
  end

  // ****************************************
  // voltage readings and freeze
  // ****************************************
  // a frozen set stays consistent: top and low bits
  // come from one conversion until the host is done
  wire nxt_freeze;
  wire nxt_core_seen;
  wire nxt_main_seen;

  assign nxt_core_seen = core_seen_ff | rd_core;
  assign nxt_main_seen = main_seen_ff | rd_main;
  // freeze from extended read to both top reads
  assign nxt_freeze = rd_ext ? 1'b1 :
    (freeze_ff & ~(nxt_core_seen & nxt_main_seen));

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      core_rd_ff <= `FCV_RST8;
      main_rd_ff <= `FCV_RST8;
      core_ext_ff <= 2'b00;
      main_ext_ff <= 2'b00;
      freeze_ff <= 1'b0;
      core_seen_ff <= 1'b0;
      main_seen_ff <= 1'b0;
    end
    else
    begin
      freeze_ff <= nxt_freeze;
      if (rd_ext)
      begin
        core_seen_ff <= 1'b0;
        main_seen_ff <= 1'b0;
      end
      else if (freeze_ff)
      begin
        core_seen_ff <= nxt_core_seen;
        main_seen_ff <= nxt_main_seen;
      end
      // no update while frozen
      // hold from the ext read setup, where prdata is captured
      if (sample_valid & ~freeze_ff & ~(psel & ~pwrite & ext_hit))
      begin
        core_rd_ff <= core_supply_input[9:2];
        main_rd_ff <= main_supply_input[9:2];
        core_ext_ff <= core_supply_input[1:0];
        main_ext_ff <= main_supply_input[1:0];
      end
    end
  end

  // ****************************************
  // core supply guard
  // ****************************************
  wire core_below;
  wire guard_on;

  assign core_below = core_rd_ff < core_low_limit;
  assign guard_on = smooth_ff[`FCV_CORE_GUARD];

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      core_low_ff <= 1'b0;
      processor_hot_mon_en <= 1'b1;
      fan_spinup <= 1'b0;
    end
    else
    begin
      fan_spinup <= 1'b0;
      // enter low state, stop hot monitoring
      if (guard_on & core_below & ~core_low_ff)
      begin
        core_low_ff <= 1'b1;
        processor_hot_mon_en <= 1'b0;
      end
      else if (core_low_ff & ~core_below)
      begin
        core_low_ff <= 1'b0;
        processor_hot_mon_en <= 1'b1;
        fan_spinup <= 1'b1;
      end
    end
  end

  // ****************************************
  // thermal limit
  // ****************************************
  wire thermal_limit_signal_en;
  wire thermal_limit_signal_release;

  // manual mode needs the enable bit
  assign thermal_limit_signal_en = ~manual_mode | smooth_ff[`FCV_THM_MAN];
  // no hysteresis band when bit set
  assign thermal_limit_signal_release = thys_ff[`FCV_HYS_OFF] ?
    ~temp_over_limit : ~temp_above_hys_band;

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      thermal_limit_signal_ff <= 1'b0;
      thermal_limit_signal <= 1'b0;
      fan_full_on <= 1'b0;
    end
    else
    begin
      if (~thermal_limit_signal_en)
        thermal_limit_signal_ff <= 1'b0;
      else if (temp_over_limit)
        thermal_limit_signal_ff <= 1'b1;
      else if (thermal_limit_signal_release)
        thermal_limit_signal_ff <= 1'b0;
      thermal_limit_signal <= thermal_limit_signal_ff;
      // override wins even with fans disabled
      fan_full_on <= thermal_limit_signal_ff | (fans_disabled & 1'b0);
    end
  end

  // ****************************************
  // smoothing scales
  // ****************************************
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      fan1_smooth_scale <= `FCV_SCALE_BASE;
      fan2_smooth_scale <= `FCV_SCALE_BASE;
      fan3_smooth_scale <= `FCV_SCALE_BASE;
    end
    else
    begin
      fan1_smooth_scale <= scale(smooth_ff[`FCV_SLOW_R1],
        smooth_ff[`FCV_FURTHER]);
      fan2_smooth_scale <= scale(smooth_ff[`FCV_SLOW_LOC],
        smooth_ff[`FCV_FURTHER]);
      fan3_smooth_scale <= scale(smooth_ff[`FCV_SLOW_R2],
        smooth_ff[`FCV_FURTHER]);
    end
  end

  // ****************************************
  // interrupt status
  // ****************************************
  reg thermal_limit_signal_d_ff;
  wire [1:0] ev;

  assign ev[`FCV_IS_CORE] = guard_on & core_below & ~core_low_ff;
  assign ev[`FCV_IS_THERMAL_LIMIT_SIGNAL] = thermal_limit_signal_ff & ~thermal_limit_signal_d_ff;

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      istat_ff <= 2'b00;
      thermal_limit_signal_d_ff <= 1'b0;
    end
    else
    begin
      thermal_limit_signal_d_ff <= thermal_limit_signal_ff;
      // status bit; a new event beats the read clear
      istat_ff <= (rd_istat ? 2'b00 : istat_ff) | ev;
    end
  end

  assign irq = |(istat_ff & imask_ff);

  // ****************************************
  // read data
  // ****************************************
  reg [7:0] rsel;

  always @*
  begin
    case (idx)
      `FCV_IDX_SMOOTH:
        rsel = smooth_ff;
      `FCV_IDX_THYS:
        rsel = thys_ff;
      `FCV_IDX_CORE:
        rsel = core_rd_ff;
      `FCV_IDX_MAIN:
        rsel = main_rd_ff;
      `FCV_IDX_CFG1:
        rsel = {6'h00, lock_ff, 1'b0};
      `FCV_IDX_ISTAT:
        rsel = {6'h00, istat_ff | ev};
      `FCV_IDX_IMASK:
        rsel = {6'h00, imask_ff};
      `FCV_IDX_EXT1:
        rsel = {2'b00, main_ext_ff, core_ext_ff, 2'b00};
      default:
        rsel = `FCV_RST8;
    endcase
  end

  // captured in setup so the access phase sees a flop
  always @(posedge clk)
  begin
    if (!rstn)
      prdata <= `FCV_RD_ZERO;
    else if (setup & ~pwrite)
      prdata <= mapped ? {24'h00_0000, rsel} : `FCV_RD_ZERO;
  end

endmodule

// [verif/fcv_top_props.sv]
`timescale 1ns/10ps
module fcv_chk
(
  // clock and reset
  input wire clk,
  input wire rstn,
  // bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  // thermal and monitor
  input wire temp_over_limit,
  input wire manual_mode,
  input wire thermal_limit_signal,
  input wire fan_full_on,
  input wire processor_hot_mon_en,
  input wire fan_spinup,
  input wire [12:0] fan1_smooth_scale
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence over_auto;
    temp_over_limit && !manual_mode;
  endsequence
  sequence bad_rd;
    psel && !penable && !pwrite && paddr[1:0] != 2'b00;
  endsequence
  thermal_limit_signal_engage_a: assert property (over_auto [*3] |=>
    thermal_limit_signal)
    else $error("thermal limit not raised");
  full_on_a: assert property (fan_full_on == thermal_limit_signal)
    else $error("full on differs from thermal limit");
  spin_rise_a: assert property (
    $rose(processor_hot_mon_en) |-> fan_spinup)
    else $error("no spin-up on recovery");
  spin_pulse_a: assert property (fan_spinup |=> !fan_spinup)
    else $error("spin-up longer than one cycle");
  upper_zero_a: assert property (prdata[31:8] == 24'h0000_00)
    else $error("read data upper bits set");
  slverr_unal_a: assert property (
    psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("unaligned access not refused");
  unal_zero_a: assert property (bad_rd |=> prdata == 32'h0000_0000)
    else $error("unaligned read not zero");
  scale_legal_a: assert property (fan1_smooth_scale inside
    {13'h03E8, 13'h0FA0, 13'h0570, 13'h15C0})
    else $error("fan 1 scale off");
endmodule
bind fcv_top fcv_chk fcv_chk_inst (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .temp_over_limit(temp_over_limit),
  .manual_mode(manual_mode), .thermal_limit_signal(thermal_limit_signal),
  .fan_full_on(fan_full_on), .processor_hot_mon_en(processor_hot_mon_en),
  .fan_spinup(fan_spinup), .fan1_smooth_scale(fan1_smooth_scale));

// [verif/fcv_host.sv]
`timescale 1ns/10ps
module fcv_host
(
  // clock
  input wire clk,
  // apb master
  output reg psel,
  output reg penable,
  output reg pwrite,
  output reg [9:0] paddr,
  output reg [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  // results
  output reg rd_done,
  output reg [31:0] rd_data,
  output reg hang
);
  initial
  begin
    {psel, penable, pwrite, rd_done, hang} = 5'h00;
    paddr = 10'h3FF;
    pwdata = 32'h0000_0000;
    rd_data = 32'h0000_0000;
  end
  task xfer(input w, input [9:0] a, input [7:0] d);
    integer n;
    reg [7:0] m;
    begin
      m = d;
      if (a == 10'h040 || a == 10'h044)
        m = d & (a[2] ? 8'h01 : 8'hCF);
      @(posedge clk);
      {psel, penable, pwrite} <= {1'b1, 1'b0, w};
      paddr <= a;
      pwdata <= {24'h0000_00, m};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 64)
      begin
        @(posedge clk);
        n = n + 1;
      end
      if (n >= 64)
        hang <= 1'b1;
      rd_data <= prdata;
      rd_done <= !w;
      {psel, penable} <= 2'b00;
      // released lines show no stale value
      paddr <= ~a;
      pwdata <= ~pwdata;
      @(posedge clk);
      rd_done <= 1'b0;
    end
  endtask
endmodule

// [verif/tb.sv]
`timescale 1ns/10ps
module tb;
  reg clk, rstn, sv, over, hys, man, fdis;
  reg [9:0] core, mainv, c, m;
  reg [7:0] lim, d;
  reg [31:0] seed, e;
  reg [31:0] q[$];
  wire psel, penable, pwrite, pready, pslverr, irq, thm, full, hot, spin;
  wire rd_done, hang;
  wire [9:0] paddr;
  wire [31:0] pwdata, prdata, rd_data;
  wire [12:0] s1, s2, s3;
  integer err_count, compares, i, nspin;
  fcv_top fcv_top_inst (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sample_valid(sv), .core_supply_input(core), .main_supply_input(mainv),
    .core_low_limit(lim), .temp_over_limit(over),
    .temp_above_hys_band(hys), .manual_mode(man), .fans_disabled(fdis),
    .thermal_limit_signal(thm), .fan_full_on(full),
    .processor_hot_mon_en(hot), .fan_spinup(spin), .fan1_smooth_scale(s1),
    .fan2_smooth_scale(s2), .fan3_smooth_scale(s3), .irq(irq));
  fcv_host fcv_host_inst (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .rd_done(rd_done), .rd_data(rd_data), .hang(hang));
  // ****************
  // helpers
  // ****************
  task chk(input [31:0] ex, input [31:0] got, input [8*6:1] nm);
    begin
      compares = compares + 1;
      if (got !== ex)
      begin
        err_count = err_count + 1;
        $display("Error %0s exp %h got %h", nm, ex, got);
      end
    end
  endtask
  task rd(input [7:0] x, input [31:0] ex);
    begin
      q.push_back(ex);
      fcv_host_inst.xfer(1'b0, {x, 2'b00}, 8'h00);
    end
  endtask
  task wr(input [7:0] x, input [7:0] v);
    fcv_host_inst.xfer(1'b1, {x, 2'b00}, v);
  endtask
  task smp(input [9:0] a, input [9:0] b);
    begin
      @(posedge clk);
      {sv, core, mainv} <= {1'b1, a, b};
      @(posedge clk);
      sv <= 1'b0;
    end
  endtask
  task wt;
    repeat (3) @(posedge clk);
  endtask
  function [31:0] xs(input integer u);
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      xs = seed;
    end
  endfunction
  function [12:0] sc(input s, input f);
    sc = f ? (s ? 13'h15C0 : 13'h0570) : (s ? 13'h0FA0 : 13'h03E8);
  endfunction
  task tally_and_finish;
    begin
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // ****************
  // clock, monitor, limits
  // ****************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (spin === 1'b1)
      nspin = nspin + 1;
    if (rd_done === 1'b1)
    begin
      e = q.pop_front();
      chk(e, rd_data, "rdata");
    end
  end
  always @(posedge hang)
  begin
    err_count = err_count + 1;
    tally_and_finish;
  end
  // ****************
  // main sequence
  // ****************
  initial
  begin
    {rstn, sv, over, hys, man, fdis} = 6'h00;
    {core, mainv, lim} = 28'h000_0000;
    {seed, err_count, compares, nspin} = {32'd40, 32'd0, 32'd0, 32'd0};
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h10, 0);
    rd(8'h11, 0);
    rd(8'h21, 0);
    rd(8'h22, 0);
    $display("reset test done");
    for (i = 0; i < 12; i = i + 1)
    begin
      d = xs(0);
      wr(8'h10, d);
      rd(8'h10, d & 8'hCF);
      chk(sc(d[0], d[7]), s1, "scale1");
      chk(sc(d[1], d[7]), s2, "scale2");
      chk(sc(d[2], d[7]), s3, "scale3");
    end
    $display("smoothing test done");
    wr(8'h10, 8'h00);
    {man, fdis, over, hys} <= 4'hF;
    wt;
    chk(0, thm, "thermal_limit_signal");
    wr(8'h10, 8'h08);
    wt;
    chk(1, full, "fullon");
    over <= 1'b0;
    wt;
    chk(1, thm, "thermal_limit_signal");
    wr(8'h11, 8'h01);
    wt;
    chk(0, thm, "thermal_limit_signal");
    {man, over} <= 2'b01;
    wt;
    wt;
    chk(1, thm, "thermal_limit_signal");
    over <= 1'b0;
    wt;
    chk(0, thm, "thermal_limit_signal");
    $display("thermal test done");
    c = xs(0) & 10'h1FF;
    m = xs(0);
    smp(c, m);
    wr(8'h21, 8'hFF);
    rd(8'h21, c[9:2]);
    rd(8'h76, {m[1:0], c[1:0], 2'b00});
    smp(~c, ~m);
    rd(8'h21, c[9:2]);
    rd(8'h22, m[9:2]);
    smp(c ^ 10'h00C, m);
    rd(8'h21, c[9:2] ^ 8'h03);
    $display("voltage test done");
    wr(8'h42, 8'h02);
    chk(0, irq, "irq");
    wr(8'h10, 8'h40);
    lim <= 8'hFF;
    wt;
    chk(0, hot, "hotmon");
    chk(1, irq, "irq");
    lim <= 8'h00;
    wt;
    chk(1, hot, "hotmon");
    chk(1, nspin, "spinup");
    rd(8'h41, 3);
    rd(8'h41, 0);
    $display("guard test done");
    wr(8'h40, 8'h02);
    wr(8'h10, 8'h07);
    wr(8'h11, 8'h00);
    wr(8'h40, 8'h00);
    rd(8'h10, 8'h40);
    rd(8'h11, 8'h01);
    rd(8'h40, 8'h02);
    rd(8'h30, 0);
    q.push_back(0);
    fcv_host_inst.xfer(1'b0, 10'h041, 8'h00);
    $display("lock test done");
    repeat (2) @(posedge clk);
    tally_and_finish;
  end
endmodule
